// File: common/dpli_regs.vh
// constants for the dual-port lvds pixel input receiver
// assumes a 25 MHz core clock sampling the link lines directly
`ifndef DPLI_REGS_VH
`define DPLI_REGS_VH
`define DPLI_BITS_PER_CLOCK 7
`define DPLI_LANES          4
`define DPLI_COLOR_WIDTH    8
`define DPLI_FMT_VESA       1'b1
`define DPLI_FMT_JEIDA      1'b0
`define DPLI_LINE_WIDTH     960
`define DPLI_PIX_IDX_WIDTH  12
`endif

// File: verilog/dpli_receiver.v
// dual-port lvds pixel receiver: deserialises odd and even ports, decodes rgb + data enable
// assumes lane and clock lines arrive as single-ended levels from outside the core_clk domain
//
// Contract
// - each link clock carries two pixels; odd port first, even port second.
// - two ports, odd and even, each four data lanes plus own clock.
// - bit_order_select high or open selects vesa order, low selects jeida order. the code has no pull-up, so an open strap is not forced to vesa.
// - colour components are 8-bit unsigned levels, larger is brighter.
// - bit 7 is msb and bit 0 is lsb for every colour.
// - all zeros black, all ones white, primaries and mixes follow directly.
// - a colour bit one is a high line level, zero is low.
// - each port carries a data enable timed by its own clock.
// - only data enable gives timing; line bounds come from its edges. the code also restarts the pixel index after LINE_WIDTH pairs.
`timescale 1ns/1ps
`include "dpli_regs.vh"
module dpli_receiver #(
  parameter LINE_WIDTH = `DPLI_LINE_WIDTH
) (
  input  wire        core_clk,             // core clock, 25 MHz
  input  wire        reset,                // synchronous, active high
  input  wire [3:0]  odd_lane_p,           // odd port lanes 0..3
  input  wire        odd_port_clock_p,     // odd port link clock
  input  wire [3:0]  even_lane_p,          // even port lanes 0..3
  input  wire        even_port_clock_p,    // even port link clock
  input  wire        bit_order_select,     // 1 vesa, 0 jeida
  output reg  [7:0]  odd_red_level,        // odd pixel red
  output reg  [7:0]  odd_green_level,      // odd pixel green
  output reg  [7:0]  odd_blue_level,       // odd pixel blue
  output reg  [7:0]  even_red_level,       // even pixel red
  output reg  [7:0]  even_green_level,     // even pixel green
  output reg  [7:0]  even_blue_level,      // even pixel blue
  output reg         pixel_valid,          // one-cycle strobe, pixel pair stored
  output reg  [11:0] odd_pixel_index,      // 2k+1 index within line
  output reg  [11:0] even_pixel_index,     // 2k+2 index within line
  output reg         line_start,           // pulse at first pair of a line
  output reg         line_end              // pulse at data enable fall
);

  // decode one pixel from 4x7 captured bits; returns {de,r,g,b}
  function [24:0] dpli_decode;
    input [27:0] w;   // lane l slot s at w[l*7+s], slot 0 first
    input        vesa;
    reg [6:0] a, b, c, d;
    reg [7:0] r, g, bl;
    begin
      a = w[6:0];
      b = w[13:7];
      c = w[20:14];
      d = w[27:21];
      if (vesa)
      begin
        r  = {d[1], d[0], a[5], a[4], a[3], a[2], a[1], a[0]};
        g  = {d[3], d[2], b[4], b[3], b[2], b[1], b[0], a[6]};
        bl = {d[5], d[4], c[3], c[2], c[1], c[0], b[6], b[5]};
      end
      else
      begin
        r  = {a[5], a[4], a[3], a[2], a[1], a[0], d[1], d[0]};
        g  = {b[4], b[3], b[2], b[1], b[0], a[6], d[3], d[2]};
        bl = {c[3], c[2], c[1], c[0], b[6], b[5], d[5], d[4]};
      end
      dpli_decode = {c[6], r, g, bl};
    end
  endfunction

  // two-flop synchronisers for all link lines and the strap
  reg [4:0] odd_s1_reg, odd_s2_reg, even_s1_reg, even_s2_reg;
  reg       sel_s1_reg, sel_s2_reg;
  always @(posedge core_clk)
  begin
    odd_s1_reg  <= {odd_port_clock_p, odd_lane_p};
    odd_s2_reg  <= odd_s1_reg;
    even_s1_reg <= {even_port_clock_p, even_lane_p};
    even_s2_reg <= even_s1_reg;
    sel_s1_reg  <= bit_order_select;
    sel_s2_reg  <= sel_s1_reg;
  end

  // clock edge detection on the second stage only
  reg odd_clk_d_reg, even_clk_d_reg;
  always @(posedge core_clk)
  begin
    odd_clk_d_reg  <= odd_s2_reg[4];
    even_clk_d_reg <= even_s2_reg[4];
  end
  wire odd_rise  = odd_s2_reg[4] & ~odd_clk_d_reg;
  wire even_rise = even_s2_reg[4] & ~even_clk_d_reg;

  // seven samples per lane per link period; the link clock rises at slot boundary 0
  // limitation: core_clk sampling only works when the bench link runs slowly
  reg [2:0]  odd_slot_reg, even_slot_reg;
  reg [27:0] odd_sh_reg, even_sh_reg, odd_word_reg, even_word_reg;
  reg        odd_word_ok_reg, even_word_ok_reg;
  reg        odd_run_reg, even_run_reg;
  integer l;
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      odd_slot_reg     <= 3'h0;
      even_slot_reg    <= 3'h0;
      odd_sh_reg       <= 28'h0;
      even_sh_reg      <= 28'h0;
      odd_word_reg     <= 28'h0;
      even_word_reg    <= 28'h0;
      odd_word_ok_reg  <= 1'b0;
      even_word_ok_reg <= 1'b0;
      odd_run_reg      <= 1'b0;
      even_run_reg     <= 1'b0;
    end
    else
    begin
      odd_word_ok_reg  <= 1'b0;
      even_word_ok_reg <= 1'b0;
      if (odd_rise)
      begin
        odd_slot_reg <= 3'h1;
        odd_run_reg  <= 1'b1;
        if (odd_run_reg)
        begin
          odd_word_reg    <= odd_sh_reg;
          odd_word_ok_reg <= 1'b1;
        end
        for (l = 0; l < `DPLI_LANES; l = l + 1)
          odd_sh_reg[l*7] <= odd_s2_reg[l];
      end
      else if (odd_run_reg && odd_slot_reg < `DPLI_BITS_PER_CLOCK)
      begin
        for (l = 0; l < `DPLI_LANES; l = l + 1)
          odd_sh_reg[l*7 + odd_slot_reg] <= odd_s2_reg[l];
        odd_slot_reg <= odd_slot_reg + 3'h1;
      end
      if (even_rise)
      begin
        even_slot_reg <= 3'h1;
        even_run_reg  <= 1'b1;
        if (even_run_reg)
        begin
          even_word_reg    <= even_sh_reg;
          even_word_ok_reg <= 1'b1;
        end
        for (l = 0; l < `DPLI_LANES; l = l + 1)
          even_sh_reg[l*7] <= even_s2_reg[l];
      end
      else if (even_run_reg && even_slot_reg < `DPLI_BITS_PER_CLOCK)
      begin
        for (l = 0; l < `DPLI_LANES; l = l + 1)
          even_sh_reg[l*7 + even_slot_reg] <= even_s2_reg[l];
        even_slot_reg <= even_slot_reg + 3'h1;
      end
    end
  end

  // pair ports: hold the first finished word until the other arrives
  reg [27:0] odd_hold_reg, even_hold_reg;
  reg        odd_have_reg, even_have_reg;
  wire       odd_have_n  = odd_have_reg | odd_word_ok_reg;
  wire       even_have_n = even_have_reg | even_word_ok_reg;
  wire [27:0] odd_w  = odd_word_ok_reg ? odd_word_reg : odd_hold_reg;
  wire [27:0] even_w = even_word_ok_reg ? even_word_reg : even_hold_reg;
  wire [24:0] odd_px  = dpli_decode(odd_w, sel_s2_reg);
  wire [24:0] even_px = dpli_decode(even_w, sel_s2_reg);
  wire        pair    = odd_have_n & even_have_n;
  wire        de_both = odd_px[24] & even_px[24];

  // line pulses from data enable only, index also restarts after LINE_WIDTH pairs; pixels written as 2k+1, 2k+2
  reg        de_prev_reg;
  reg [11:0] pos_reg;
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      odd_hold_reg     <= 28'h0;
      even_hold_reg    <= 28'h0;
      odd_have_reg     <= 1'b0;
      even_have_reg    <= 1'b0;
      de_prev_reg      <= 1'b0;
      pos_reg          <= 12'h0;
      pixel_valid      <= 1'b0;
      line_start       <= 1'b0;
      line_end         <= 1'b0;
      odd_red_level    <= 8'h00;
      odd_green_level  <= 8'h00;
      odd_blue_level   <= 8'h00;
      even_red_level   <= 8'h00;
      even_green_level <= 8'h00;
      even_blue_level  <= 8'h00;
      odd_pixel_index  <= 12'h0;
      even_pixel_index <= 12'h0;
    end
    else
    begin
      pixel_valid <= 1'b0;
      line_start  <= 1'b0;
      line_end    <= 1'b0;
      if (odd_word_ok_reg)
        odd_hold_reg <= odd_word_reg;
      if (even_word_ok_reg)
        even_hold_reg <= even_word_reg;
      odd_have_reg  <= pair ? 1'b0 : odd_have_n;
      even_have_reg <= pair ? 1'b0 : even_have_n;
      if (pair)
      begin
        de_prev_reg <= de_both;
        if (de_both)
        begin
          // levels pass straight through: code maps monotonically to brightness
          odd_red_level    <= odd_px[23:16];
          odd_green_level  <= odd_px[15:8];
          odd_blue_level   <= odd_px[7:0];
          even_red_level   <= even_px[23:16];
          even_green_level <= even_px[15:8];
          even_blue_level  <= even_px[7:0];
          odd_pixel_index  <= pos_reg + 12'h1;
          even_pixel_index <= pos_reg + 12'h2;
          pos_reg          <= (pos_reg + 12'h2 >= LINE_WIDTH[11:0] * 12'h2) ? 12'h0 : pos_reg + 12'h2;
          pixel_valid      <= 1'b1;
          line_start       <= ~de_prev_reg;
        end
        else
        begin
          pos_reg  <= 12'h0;
          line_end <= de_prev_reg;
        end
      end
    end
  end

endmodule

// File: dv/dpli_sva.sv
// checker for the stored pixel pair strobe, indices and line pulses
// bound into dpli_receiver, sees only its ports
`timescale 1ns/1ps
module dpli_sva #(
  parameter LINE_WIDTH = 960
) (
  input wire        core_clk,         // clock
  input wire        reset,            // sync reset
  input wire        pixel_valid,      // pair strobe
  input wire [11:0] odd_pixel_index,  // 2k+1
  input wire [11:0] even_pixel_index, // 2k+2
  input wire        line_start,       // first pair
  input wire        line_end          // enable fall
);
  reg  [11:0] last_reg;
  wire [11:0] step = last_reg + 12'h002;
  // odd index of the previous pair; stale after reset, but the next pair is a line start
  always @(posedge core_clk)
    if (pixel_valid)
      last_reg <= odd_pixel_index;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_STROBE: assert property (pixel_valid |=> !pixel_valid [*6]) else $error("pair strobe too close");
  AST_PAIR: assert property (pixel_valid |-> even_pixel_index == odd_pixel_index + 12'h001) else $error("pair idx");
  AST_ODD: assert property (pixel_valid |-> odd_pixel_index[0]) else $error("odd index even");
  AST_START: assert property (line_start |-> pixel_valid && odd_pixel_index == 12'h001) else $error("start");
  AST_STEP: assert property (pixel_valid && !line_start |->
    odd_pixel_index == ((step > 2 * LINE_WIDTH) ? 12'h001 : step)) else $error("index step");
  AST_HOLD: assert property (!pixel_valid && !$past(reset) |-> $stable(odd_pixel_index)) else $error("hold");
  AST_END: assert property (line_end |-> !pixel_valid) else $error("end with pair");
  AST_BOOT: assert property ($fell(reset) |-> !pixel_valid [*8]) else $error("pair after reset");
endmodule
bind dpli_receiver dpli_sva #(.LINE_WIDTH(LINE_WIDTH)) chk (.core_clk(core_clk), .reset(reset),
  .pixel_valid(pixel_valid), .odd_pixel_index(odd_pixel_index), .even_pixel_index(even_pixel_index),
  .line_start(line_start), .line_end(line_end));

// File: dv/dpli_tx_model.sv
// one transmitter port: four lanes of seven slots plus a 320 ns link clock
// assumes the pixel is changed just after each link clock rise
`timescale 1ns/1ps
module dpli_tx_model (
  input  wire        vesa, // bit order
  input  wire [23:0] rgb,  // {r, g, b}
  input  wire        de,   // data enable
  output reg  [3:0]  lane, // data lanes
  output reg         lclk  // link clock
);
  reg [27:0] w;
  reg [7:0]  r, g, b;
  integer    s;
  integer    l;
  // slot s of lane l is w[l*7+s]; reserved slots low; eighth slot is idle filler
  always
  begin
    {r, g, b} = rgb;
    if (vesa)
      w = {1'b0, b[7:6], g[7:6], r[7:6], de, 2'b00, b[5:2], b[1:0], g[5:1], g[0], r[5:0]};
    else
      w = {1'b0, b[1:0], g[1:0], r[1:0], de, 2'b00, b[7:4], b[3:2], g[7:3], g[2], r[7:2]};
    for (s = 0; s < 8; s = s + 1)
    begin
      lclk = (s < 4);
      for (l = 0; l < 4; l = l + 1)
        lane[l] = (s < 7) && w[l * 7 + s % 7];
      #40;
    end
  end
endmodule

// File: dv/dpli_receiver_bench.sv
// bench: two transmitter models drive dpli_receiver, stored pairs are judged
// assumes 40 ns core clock, 320 ns link clock, LINE_WIDTH cut to 8
`timescale 1ns/1ps
`include "dpli_regs.vh"
module dpli_receiver_bench;
  reg         core_clk = 1'b0;
  reg         reset = 1'b1;
  reg         bit_order_select = `DPLI_FMT_VESA;
  reg  [23:0] o_rgb = 24'h000000;
  reg  [23:0] e_rgb = 24'h000000;
  reg         o_de = 1'b0;
  reg         e_de = 1'b0;
  wire [3:0]  ol, el;
  wire        oc, ec, pv, ls, le;
  wire [7:0]  orr, og, ob, er, eg, eb;
  wire [11:0] oi, ei;
  integer     num_errors = 0;
  integer     n_tests = 0;
  integer     k = 0;
  integer     nv = 0;
  integer     ne = 0;
  dpli_tx_model odd_tx (.vesa(bit_order_select), .rgb(o_rgb), .de(o_de), .lane(ol), .lclk(oc));
  dpli_tx_model even_tx (.vesa(bit_order_select), .rgb(e_rgb), .de(e_de), .lane(el), .lclk(ec));
  dpli_receiver #(.LINE_WIDTH(8)) dut (.core_clk(core_clk), .reset(reset), .odd_lane_p(ol),
    .odd_port_clock_p(oc), .even_lane_p(el), .even_port_clock_p(ec), .bit_order_select(bit_order_select),
    .odd_red_level(orr), .odd_green_level(og), .odd_blue_level(ob), .even_red_level(er),
    .even_green_level(eg), .even_blue_level(eb), .pixel_valid(pv), .odd_pixel_index(oi),
    .even_pixel_index(ei), .line_start(ls), .line_end(le));
  always #20 core_clk = ~core_clk;
  // odd side walks all eight full-scale colours, even side walking-one and ramps
  function [23:0] opat(input integer j);
    opat = {{8{j[2]}}, {8{j[1]}}, {8{j[0]}}};
  endfunction
  function [23:0] epat(input integer j);
    epat = {8'h01 << (j % 8), 8'(8'hff - j * 17), 8'(j * 29 + 3)};
  endfunction
  task cmp(input [63:0] what, input [23:0] exp, input [23:0] got);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // judge each pair once the edge has settled; the index wraps every 8 pairs
  always @(posedge core_clk)
  begin
    #1;
    ne = ne + (le === 1'b1);
    if (pv === 1'b1)
    begin
      cmp("odd", opat(k), {orr, og, ob});
      cmp("even", epat(k), {er, eg, eb});
      cmp("index", {12'(k % 8 * 2 + 1), 12'(k % 8 * 2 + 2)}, {oi, ei});
      cmp("start", 24'(k == 0), 24'(ls));
      k = k + 1;
      nv = nv + 1;
    end
  end
  // one line of n pairs then blanking; one_side drops even-port enable
  task run_line(input fmt, input integer n, input integer one_side);
    integer j;
    integer v0;
    integer e0;
  begin
    @(negedge core_clk);
    bit_order_select = fmt;
    repeat (3) @(posedge oc);
    v0 = nv;
    e0 = ne;
    k = 0;
    for (j = 0; j < n + 3; j = j + 1)
    begin
      @(posedge oc) #5;
      o_rgb = opat(j);
      e_rgb = epat(j);
      o_de = (j < n);
      e_de = (j < n) && (one_side == 0);
    end
    // the enable-low word that ends the line only shows up about 140 ns after the last link rise
    repeat (8) @(posedge core_clk);
    cmp("pairs", 24'(one_side ? v0 : v0 + n), 24'(nv));
    cmp("ends", 24'(one_side ? e0 : e0 + 1), 24'(ne));
  end
  endtask
  task t_vesa;
    run_line(`DPLI_FMT_VESA, 12, 0);
  endtask
  task t_refuse;
    run_line(`DPLI_FMT_VESA, 3, 1);
  endtask
  task t_jeida;
    run_line(`DPLI_FMT_JEIDA, 9, 0);
  endtask
  task t_reset;
  begin
    @(negedge core_clk);
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    cmp("rst_idx", 24'h000000, {oi, ei});
    run_line(`DPLI_FMT_VESA, 5, 0);
  end
  endtask
  task end_sim;
  begin
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial
  begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    t_vesa;
    t_refuse;
    t_jeida;
    t_reset;
    end_sim;
  end
endmodule
